/* File: hw/otu_pkg.sv */
`default_nettype none
package otu_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRESCALE = 8'h04;
  localparam logic [7:0] ADDR_COUNTER = 8'h08;
  localparam logic [7:0] ADDR_RELOAD0 = 8'h0c;
  localparam logic [7:0] ADDR_RELOAD1 = 8'h10;
  localparam logic [7:0] ADDR_OUT_LEVEL = 8'h14;
  localparam logic [7:0] ADDR_FF_DATA = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  // control and status field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_EXT_BIT = 3;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_FF_BIT = 1;
  localparam int STAT_PHASE_BIT = 2;
  // reload value that selects 0% or 100% duty
  localparam logic [15:0] RELOAD_DUTY_EDGE = 16'hffff;
  // reset values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // output modes
  typedef enum logic [1:0] {
    MODE_PWM = 2'b00,
    MODE_OSPWM = 2'b01,
    MODE_ONESHOT = 2'b10,
    MODE_CONT = 2'b11
  } otu_mode_e;
  // counter sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } otu_state_e;
endpackage
`default_nettype wire

/* File: hw/otu_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
// count clock enable: one aclk-wide tick every div+1 cycles
module otu_prescaler #(
  parameter int DIV_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);
  logic [DIV_W-1:0] cnt_reg; // cycles since last tick

  // free running so the count clock phase is independent of enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg >= div) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hw/otu_timer.sv */
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: continuous mode reloads on every underflow
// R2: intervals are start+1, then reload+1
// R3: continuous output alternates inverted and true
// R4: underflow request on every underflow
// R5: software disable beats external enable
// R6: counter shows reload at underflow, then minus
// R7: start waits for next count clock
// R8: reload ffff means 0% or 100% duty
// R9: software programs desired count minus one
// R10: never both reloads ffff together
// R11: no ffff writes while running
// R12: requests continue at 0% or 100%
// R13: pwm 0% true level, 100% inverse
// R14: one-shot pwm 0% inverse, 100% true
// R15: level write loads both level and data
// R16: data write updates output at once
// R17: level and data writable any time
// R18: disable holds current data value
// R19: pwm reload0 ffff: true level, reload1 period
// R20: pwm reload1 ffff: inverse, reload0 period
// R21: one-shot pwm single ffff: inverse then restore
// R22: one-shot pwm true, inverse, then true
// R23: one-shot inverse at start, true at stop
// R24: mode field selects one of four sequences
module otu_timer
  import otu_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_enable,
  output logic timer_out,
  output logic underflow_req
);
  // bus slave state
  logic aw_have_reg; // write address latched
  logic w_have_reg; // write data latched
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_do; // both halves present, commit now
  logic wr_hit; // committed address is mapped

  // timer registers
  otu_mode_e mode_reg;
  logic ext_allow_reg; // external enable input permitted
  logic [DIV_W-1:0] pre_reg;
  logic [15:0] cnt_reg;
  logic [15:0] rl0_reg;
  logic [15:0] rl1_reg;
  logic olc_reg; // output_level_control
  logic ffd_reg; // flipflop_output_data, drives the pin
  logic ph_reg; // pwm phase, or continuous underflow parity
  otu_state_e state_reg;

  // external enable synchroniser and edge detect
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_d_reg;
  logic ext_rise;
  logic tick;

  // decoded write strobes
  logic wr_ctrl, wr_pre, wr_cnt, wr_rl0, wr_rl1, wr_olc, wr_ffd;
  logic sw_en, sw_dis, ext_go;
  logic start_go, uf;
  logic r0_edge, r1_edge;

  // next-value terms of the sequencer
  logic ph_next;
  logic [15:0] uf_load;
  logic [15:0] start_load;
  logic uf_out;
  logic start_out;
  logic stop_now;
  logic start_ph;

  // merge byte lanes 0 and 1 into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  otu_prescaler #(.DIV_W(DIV_W)) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(pre_reg),
    .tick(tick)
  );

  // write address and data channels are taken independently
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign wr_do = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // write channel latching
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_do) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // write address decode; status is read-only
  always_comb begin
    wr_ctrl = wr_do && waddr_reg == ADDR_CTRL;
    wr_pre = wr_do && waddr_reg == ADDR_PRESCALE;
    wr_cnt = wr_do && waddr_reg == ADDR_COUNTER;
    wr_rl0 = wr_do && waddr_reg == ADDR_RELOAD0;
    wr_rl1 = wr_do && waddr_reg == ADDR_RELOAD1;
    wr_olc = wr_do && waddr_reg == ADDR_OUT_LEVEL && wstrb_reg[0];
    wr_ffd = wr_do && waddr_reg == ADDR_FF_DATA && wstrb_reg[0];
    wr_hit = wr_ctrl || wr_pre || wr_cnt || wr_rl0 || wr_rl1 ||
             (wr_do && waddr_reg == ADDR_OUT_LEVEL) ||
             (wr_do && waddr_reg == ADDR_FF_DATA);
  end

  // write response, slverr for unmapped or read-only offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one outstanding read, data from a register
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_CTRL: begin
          s_axi_rdata[CTRL_EN_BIT] <= state_reg != ST_IDLE;
          s_axi_rdata[CTRL_MODE_LSB +: 2] <= mode_reg;
          s_axi_rdata[CTRL_EXT_BIT] <= ext_allow_reg;
        end
        ADDR_PRESCALE: s_axi_rdata[DIV_W-1:0] <= pre_reg;
        ADDR_COUNTER: s_axi_rdata[15:0] <= cnt_reg; // [R6]
        ADDR_RELOAD0: s_axi_rdata[15:0] <= rl0_reg;
        ADDR_RELOAD1: s_axi_rdata[15:0] <= rl1_reg;
        ADDR_OUT_LEVEL: s_axi_rdata[0] <= olc_reg;
        ADDR_FF_DATA: s_axi_rdata[0] <= ffd_reg;
        ADDR_STATUS: begin
          s_axi_rdata[STAT_RUN_BIT] <= state_reg == ST_RUN;
          s_axi_rdata[STAT_FF_BIT] <= ffd_reg;
          s_axi_rdata[STAT_PHASE_BIT] <= ph_reg;
        end
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // external enable pin: two flops, then edge detect on the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_enable;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg <= ext_s2_reg;
    end
  end
  assign ext_rise = ext_s2_reg && !ext_d_reg;

  // enable sources; a disable write always suppresses the pin
  assign sw_en = wr_ctrl && wstrb_reg[0] && wdata_reg[CTRL_EN_BIT];
  assign sw_dis = wr_ctrl && wstrb_reg[0] && !wdata_reg[CTRL_EN_BIT];
  assign ext_go = ext_rise && ext_allow_reg && !sw_dis; // [R5]
  assign r0_edge = rl0_reg == RELOAD_DUTY_EDGE; // [R8]
  assign r1_edge = rl1_reg == RELOAD_DUTY_EDGE; // [R8]
  // counting only advances on the count clock tick
  assign start_go = tick && state_reg == ST_WAIT && !sw_dis; // [R7]
  assign uf = tick && state_reg == ST_RUN && !sw_dis &&
              cnt_reg == 16'h0000;

  // per-mode sequencing: what to load and drive at start and underflow
  always_comb begin
    ph_next = ph_reg;
    uf_load = rl0_reg;
    uf_out = olc_reg;
    stop_now = 1'b0;
    start_load = rl0_reg;
    start_out = !olc_reg;
    start_ph = 1'b0;
    unique case (mode_reg) // [R24]
      MODE_PWM: begin
        // an ffff reload skips its phase entirely
        start_load = r0_edge ? rl1_reg : rl0_reg; // [R19]
        start_ph = r0_edge;
        if (r0_edge) ph_next = 1'b1; // [R19] [R13]
        else if (r1_edge) ph_next = 1'b0; // [R20] [R13]
        else ph_next = !ph_reg;
        uf_load = ph_next ? rl1_reg : rl0_reg;
        uf_out = ph_next ? olc_reg : !olc_reg; // [R19] [R20]
      end
      MODE_OSPWM: begin
        // a single-interval pulse when one reload is ffff
        start_load = r0_edge ? rl1_reg : rl0_reg;
        start_ph = r0_edge;
        start_out = (r0_edge || r1_edge) ? !olc_reg : olc_reg; // [R21] [R14]
        stop_now = ph_reg || r1_edge; // [R21]
        ph_next = 1'b1;
        uf_load = rl1_reg;
        uf_out = stop_now ? olc_reg : !olc_reg; // [R22]
      end
      MODE_ONESHOT: begin
        stop_now = 1'b1; // [R23]
        uf_out = olc_reg; // [R23]
      end
      MODE_CONT: begin
        start_load = cnt_reg; // [R2]
        ph_next = !ph_reg; // odd underflow sets parity
        uf_load = rl0_reg; // [R1]
        uf_out = ph_next ? olc_reg : !olc_reg; // [R3]
      end
    endcase
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_PWM;
      ext_allow_reg <= 1'b0;
      pre_reg <= PRESCALE_RESET[DIV_W-1:0];
      rl0_reg <= CNT_RESET;
      rl1_reg <= CNT_RESET;
    end else begin
      if (wr_ctrl && wstrb_reg[0]) begin
        mode_reg <= otu_mode_e'(wdata_reg[CTRL_MODE_LSB +: 2]);
        ext_allow_reg <= wdata_reg[CTRL_EXT_BIT];
      end
      if (wr_pre && wstrb_reg[0]) pre_reg <= wdata_reg[DIV_W-1:0];
      if (wr_rl0) rl0_reg <= merge16(rl0_reg, wdata_reg, wstrb_reg);
      if (wr_rl1) rl1_reg <= merge16(rl1_reg, wdata_reg, wstrb_reg);
    end
  end

  // sequencer state; a stop-at-underflow loses to an enable write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (sw_en || ext_go) state_reg <= ST_WAIT; // [R5]
        ST_WAIT: begin
          if (sw_dis) state_reg <= ST_IDLE; // [R18]
          else if (tick) state_reg <= ST_RUN; // [R7]
        end
        ST_RUN: begin
          if (sw_dis) state_reg <= ST_IDLE; // [R18]
          else if (uf && stop_now) begin
            state_reg <= sw_en ? ST_WAIT : ST_IDLE; // [R23]
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // counter: software write wins, else start load, reload or decrement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= CNT_RESET;
      ph_reg <= 1'b0;
    end else if (wr_cnt) begin
      cnt_reg <= merge16(cnt_reg, wdata_reg, wstrb_reg);
    end else if (start_go) begin
      cnt_reg <= start_load; // [R2]
      ph_reg <= start_ph;
    end else if (uf) begin
      cnt_reg <= uf_load; // [R1] [R6]
      ph_reg <= ph_next;
    end else if (tick && state_reg == ST_RUN && !sw_dis) begin
      cnt_reg <= cnt_reg - 16'h0001; // [R6]
    end
  end

  // level register and output flip-flop; software writes take priority
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      olc_reg <= 1'b0;
      ffd_reg <= 1'b0;
    end else if (wr_olc) begin
      olc_reg <= wdata_reg[0]; // [R15] [R17]
      ffd_reg <= wdata_reg[0]; // [R15]
    end else if (wr_ffd) begin
      ffd_reg <= wdata_reg[0]; // [R16] [R17]
    end else if (start_go) begin
      ffd_reg <= start_out; // [R3] [R21] [R22] [R23]
    end else if (uf) begin
      ffd_reg <= uf_out; // [R13] [R14]
    end
  end
  assign timer_out = ffd_reg; // [R16] [R18]

  // request pulse for interrupt, dma and other timers' activation
  always_ff @(posedge aclk) begin
    if (!aresetn) underflow_req <= 1'b0;
    else underflow_req <= uf; // [R4] [R12]
  end

  level_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_olc |=> olc_reg == ffd_reg && timer_out == olc_reg) // [R15]
    else $error("level write did not load the data flop");
  data_now_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ffd && !wr_olc |=> timer_out == $past(wdata_reg[0])) // [R16]
    else $error("data write not on output");
  dis_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_dis && ext_rise |=> state_reg == ST_IDLE) // [R5]
    else $error("external enable overrode disable");
  dis_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_dis ##1 (!wr_olc && !wr_ffd && !sw_en && !ext_go)
    |=> $stable(timer_out) && state_reg == ST_IDLE) // [R18]
    else $error("output moved after disable");
  uf_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uf && mode_reg == MODE_CONT && !wr_cnt
    |=> cnt_reg == $past(rl0_reg)) // [R1]
    else $error("continuous reload missing");
  uf_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uf |=> underflow_req ##1 !underflow_req || $past(uf)) // [R4]
    else $error("underflow request missing");
  cont_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uf && mode_reg == MODE_CONT && !wr_olc && !wr_ffd
    |=> timer_out == (ph_reg ? olc_reg : !olc_reg)) // [R3]
    else $error("continuous output phase wrong");
  start_lag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_WAIT |-> ##[1:256] state_reg != ST_WAIT) // [R7]
    else $error("start not taken within one count clock");
  pwm_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && mode_reg == MODE_PWM && !wr_olc && !wr_ffd
    |=> timer_out == !olc_reg) // [R24]
    else $error("pwm start level wrong");
  os_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uf && mode_reg == MODE_ONESHOT && !sw_en && !wr_olc && !wr_ffd
    |=> timer_out == olc_reg && state_reg == ST_IDLE) // [R23]
    else $error("one-shot did not stop on underflow");
  pwm_r0edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uf && mode_reg == MODE_PWM && r0_edge && !wr_olc && !wr_ffd
    |=> timer_out == olc_reg) // [R19]
    else $error("reload0 edge output wrong");

  cont_uf_c: cover property (@(posedge aclk) disable iff (!aresetn)
    uf && mode_reg == MODE_CONT ##[1:100] uf);
  pwm_edge_c: cover property (@(posedge aclk) disable iff (!aresetn)
    uf && mode_reg == MODE_PWM && r1_edge);
  ospwm_end_c: cover property (@(posedge aclk) disable iff (!aresetn)
    uf && mode_reg == MODE_OSPWM && ph_reg);
  os_stop_c: cover property (@(posedge aclk) disable iff (!aresetn)
    uf && mode_reg == MODE_ONESHOT);
endmodule
`default_nettype wire

/* File: test/timer_output_flipflop_modes_test.sv */
`timescale 1ns/10ps
`default_nettype none
module timer_output_flipflop_modes_test;
  import otu_pkg::*;
  // bus master side, driven on the rising edge
  logic aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic ext_enable;
  // slave answers and the timer pin
  wire logic awready, wready, bvalid, arready, rvalid, tout, ureq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int n_mismatch = 0;
  int tests_run = 0;
  // pulse and edge bookkeeping, updated on the falling edge
  int npulse = 0, cyc_p = 0, cyc_o = 0, gap_p = 0, chg_gap = 0;
  logic out_q = 1'b0;

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  otu_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_enable(ext_enable),
    .timer_out(tout), .underflow_req(ureq));

  // falling-edge sampling keeps the counts clear of the launch edge
  always @(negedge aclk) begin
    cyc_p++;
    cyc_o++;
    if (ureq === 1'b1) begin
      gap_p = cyc_p;
      cyc_p = 0;
      npulse++;
    end
    if (tout !== out_q) begin
      chg_gap = cyc_o;
      cyc_o = 0;
      out_q = tout;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one write; response ready is held high the whole run
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int i;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    // a write that never answered shows up here, not as a silent pass
    chk("bvalid", 1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // one read, masked compare of the data word
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic [1:0] er = RESP_OKAY);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    chk("rvalid", 1, {31'h0, rvalid});
    chk("rdata", e, rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // waits for n request pulses; fg is the first edge-to-edge span,
  // gp the spacing of later pulses, o0/alt the pin pattern at pulses
  task automatic watch(input int n, fg, gp, input logic o0, alt, stp);
    int k, i, s;
    for (k = 0; k < n; k++) begin
      s = npulse;
      for (i = 0; i < 3000 && npulse == s; i++) @(posedge aclk);
      chk("pulse", 1, {31'h0, npulse != s});
      if (k == 0 && fg > 0) chk("first_span", fg, chg_gap);
      if (k > 0) chk("pulse_gap", gp, gap_p);
      chk("pin", {31'h0, o0 ^ (alt & k[0])}, {31'h0, tout});
    end
    // a stopping mode must stay quiet and report not running
    if (stp) begin
      s = npulse;
      repeat (40) @(posedge aclk);
      chk("quiet", s, npulse);
      rd(ADDR_STATUS, 0, 32'h1);
    end
  endtask

  // reload pair setup with the counter stopped, so no ffff while running
  task automatic setup(input logic lvl, input logic [15:0] r0, r1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_OUT_LEVEL, {31'h0, lvl});
    wr(ADDR_RELOAD0, {16'h0, r0});
    wr(ADDR_RELOAD1, {16'h0, r1});
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the longest expected sequence
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, ext_enable} = 4'h0;
    {bready, rready} = 2'b11;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, unmapped and read-only places
    rd(ADDR_CTRL, 32'h0, 32'hffffffff);
    rd(ADDR_COUNTER, 32'h0, 32'hffffffff);
    rd(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
    // level write loads data too; data write alone shows at once
    wr(ADDR_OUT_LEVEL, 32'h1);
    rd(ADDR_FF_DATA, 32'h1, 32'h1);
    chk("pin", 1, {31'h0, tout});
    wr(ADDR_FF_DATA, 32'h0);
    chk("pin", 0, {31'h0, tout});
    rd(ADDR_OUT_LEVEL, 32'h1, 32'h1);
    // continuous: start 4, reload 5, alternating pin
    setup(1'b0, 16'h0005, 16'h0000);
    wr(ADDR_COUNTER, 32'h4);
    wr(ADDR_CTRL, 32'h7);
    watch(4, 5, 6, 1'b0, 1'b1, 1'b0);
    // pwm, plain reloads: inverse at start, then alternating
    setup(1'b0, 16'h0002, 16'h0002);
    wr(ADDR_CTRL, 32'h1);
    watch(4, 3, 3, 1'b0, 1'b1, 1'b0);
    // pwm, reload0 ffff: true level each underflow, reload1 period
    setup(1'b1, RELOAD_DUTY_EDGE, 16'h0003);
    wr(ADDR_CTRL, 32'h1);
    watch(3, 4, 4, 1'b1, 1'b0, 1'b0);
    // pwm, reload1 ffff: inverse level, reload0 period
    setup(1'b0, 16'h0002, RELOAD_DUTY_EDGE);
    wr(ADDR_CTRL, 32'h1);
    watch(3, 0, 3, 1'b1, 1'b0, 1'b0);
    rd(ADDR_RELOAD1, 32'hffff, 32'hffffffff);
    // one-shot pwm: level, inverse, then level at stop
    setup(1'b1, 16'h0002, 16'h0003);
    wr(ADDR_CTRL, 32'h3);
    watch(2, 0, 4, 1'b0, 1'b1, 1'b1);
    // one-shot pwm with a single ffff reload
    setup(1'b1, RELOAD_DUTY_EDGE, 16'h0003);
    wr(ADDR_CTRL, 32'h3);
    watch(1, 4, 0, 1'b1, 1'b0, 1'b1);
    // one-shot pwm with reload1 ffff: one reload0 interval
    setup(1'b1, 16'h0003, RELOAD_DUTY_EDGE);
    wr(ADDR_CTRL, 32'h3);
    watch(1, 4, 0, 1'b1, 1'b0, 1'b1);
    // one-shot by software enable
    setup(1'b0, 16'h0003, 16'h0000);
    wr(ADDR_CTRL, 32'h5);
    watch(1, 4, 0, 1'b0, 1'b0, 1'b1);
    // one-shot started from the external pin
    wr(ADDR_CTRL, 32'hc);
    ext_enable <= 1'b1;
    watch(1, 4, 0, 1'b0, 1'b0, 1'b1);
    ext_enable <= 1'b0;
    // pin edge timed to land in the same cycle as a disable commit
    repeat (4) @(posedge aclk);
    ext_enable <= 1'b1;
    @(posedge aclk);
    wr(ADDR_CTRL, 32'hc);
    rd(ADDR_STATUS, 32'h0, 32'h1);
    ext_enable <= 1'b0;
    // slow count clock: counter shows reload right after underflow
    setup(1'b0, 16'h0005, 16'h0000);
    wr(ADDR_PRESCALE, 32'hff);
    wr(ADDR_COUNTER, 32'h0);
    wr(ADDR_CTRL, 32'h7);
    watch(1, 0, 0, 1'b0, 1'b0, 1'b0);
    rd(ADDR_COUNTER, 32'h5, 32'hffff);
    rd(ADDR_CTRL, 32'h7, 32'hf);
    wr(ADDR_FF_DATA, 32'h1);
    chk("pin", 1, {31'h0, tout});
    // stopping holds whatever the data register has
    wr(ADDR_CTRL, 32'h6);
    rd(ADDR_STATUS, 32'h0, 32'h1);
    // longer than one slow count clock, so a stray tick would show
    repeat (300) @(posedge aclk);
    chk("pin", 1, {31'h0, tout});
    complete_run();
  end
endmodule
`default_nettype wire
